// File: core/flash_ctl_regs.sv
// Flash clock ratio, option mirror, configuration and backdoor key logic
// Function
// [R1] Loaded flag reads only; reset clears it; first ratio write sets it.
// [R2] Ratio bits 6:0 always readable; frozen after the first write.
// [R3] Erase and program refused until loaded flag is set.
// [R4] Prescale bit selects bus clock or bus clock over eight.
// [R5] Divider divides selected input by ratio field plus one.
// [R6] Each timing pulse lasts one bus clock, one pulse per flash clock period.
// [R7] Software picks settings for a 150 to 200 kHz flash clock.
// [R8] Option mirror loads from the nonvolatile option byte at reset.
// [R9] Option mirror bits 5:2 read as zero.
// [R10] Option mirror readable; bus writes have no effect.
// [R11] Backdoor disabled bit blocks key unlocking.
// [R12] Key bytes only from secured code, never from debug.
// [R13] Matching eight ascending key bytes unsecure until reset.
// [R14] Redirect disable bit turns vector redirection off.
// [R15] Only security code 1:0 means unsecured.
// [R16] Secured device blocks memory access from unsecured sources.
// [R17] Key match or full blank check sets code to 1:0.
// [R18] Config bits 7:5 read-write; bits 4:0 read zero.
// [R19] Key select routes key window writes to key capture or commands.
// [R20] Clearing key select compares captured bytes with stored key.
// [R21] Command before ratio write flags access error and is ignored.
// [R22] Config bits 7 and 6 are plain storage reset to zero.
`timescale 1ns/1ps
`default_nettype none
module flash_ctl_regs
    import flash_ctl_pkg::*;
#(
    parameter int AW = 4
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    // Register port
    input  wire logic [AW-1:0] regAddr,
    input  wire logic [7:0]    regWrData,
    input  wire logic          regWrite,
    input  wire logic          regRead,
    output logic [7:0]         regRdData,
    // Nonvolatile contents
    input  wire logic [7:0]    optionNonvolatileByte,
    input  wire logic [63:0]   backdoorKeyBytes,
    // Memory writes seen by the flash
    input  wire logic          memWrite,
    input  wire logic [15:0]   memAddr,
    input  wire logic [7:0]    memWrData,
    input  wire logic          memFromSecure,
    input  wire logic          memFromDebug,
    // Command launch and results
    input  wire logic          progEraseReq,
    input  wire logic          blankCheckPass,
    output logic               cmdGrant,
    output logic               accessError,
    output logic               fclkTick,
    // Security and option results
    input  wire logic          accessUnsecured,
    output logic               accessBlocked,
    output logic               deviceSecured,
    output logic               redirectEnable,
    output logic               optionValid
);
    typedef struct packed {
        logic [7:0]  ratio;
        logic [7:0]  option;
        logic        optLoaded;
        logic [2:0]  cfgHi;
        key_e        keySt;
        logic [3:0]  keyIdx;
        logic [63:0] keyBuf;
        logic [7:0]  rdData;
        logic        grant;
        logic        accErr;
    } ctl_s;

    ctl_s state_ff;
    ctl_s nxt_state;

    function automatic logic isReg(input logic [AW-1:0] a, input logic [3:0] idx);
        isReg = (a == AW'(idx));
    endfunction

    logic       ratioLoaded;
    logic       keySelect;
    logic       inKeyWin;
    logic [2:0] keyOff;
    logic       keyEntry;
    logic       cmdAttempt;
    logic       cfgWrite;
    logic       keyMatch;

    assign ratioLoaded = state_ff.ratio[LOADED_BIT];
    assign keySelect   = state_ff.cfgHi[KEYSEL_BIT - 5];
    assign inKeyWin    = memWrite && (memAddr[15:3] == KEY_BASE[15:3]);
    assign keyOff      = memAddr[2:0];
    // Debug writes never count as key bytes [R12]
    assign keyEntry    = inKeyWin && keySelect && memFromSecure && !memFromDebug; // [R19]
    // Key window writes launch commands when key select is clear [R19]
    assign cmdAttempt  = progEraseReq || (inKeyWin && !keySelect);
    assign cfgWrite    = regWrite && isReg(regAddr, CONFIG_IDX);
    assign keyMatch    = (state_ff.keyBuf == backdoorKeyBytes);

    always_comb begin
        nxt_state = state_ff;
        nxt_state.grant  = 1'b0;
        nxt_state.accErr = 1'b0;
        nxt_state.rdData = 8'h00;

        // Option byte captured on the first edge after reset release [R8]
        if (!state_ff.optLoaded) begin
            nxt_state.option    = optionNonvolatileByte & OPTION_USED; // [R9]
            nxt_state.optLoaded = 1'b1;
        end

        // Ratio register: one write, then frozen [R1] [R2]
        if (regWrite && isReg(regAddr, RATIO_IDX) && !ratioLoaded) begin
            nxt_state.ratio = {1'b1, regWrData[PRESCALE_BIT:0]};
        end

        // Command gating on the loaded flag [R3] [R21]
        if (cmdAttempt) begin
            if (ratioLoaded) begin
                nxt_state.grant = 1'b1;
            end else begin
                nxt_state.accErr = 1'b1;
            end
        end

        // Key byte capture, strictly ascending [R13]
        if (keyEntry && state_ff.keySt == KEY_COLLECT) begin
            if (state_ff.keyIdx < 4'(KEY_BYTES) && keyOff == state_ff.keyIdx[2:0]) begin
                nxt_state.keyBuf[8*keyOff +: 8] = memWrData;
                nxt_state.keyIdx = state_ff.keyIdx + 4'h1;
            end else begin
                nxt_state.keySt = KEY_BAD;
            end
        end

        // Config write: bits 7:5 stored, key entry opened or closed [R18] [R22]
        if (cfgWrite) begin
            nxt_state.cfgHi = regWrData[7:5];
            if (regWrData[KEYSEL_BIT] && !keySelect) begin
                nxt_state.keySt  = KEY_COLLECT;
                nxt_state.keyIdx = 4'h0;
                nxt_state.keyBuf = '0;
            end else if (!regWrData[KEYSEL_BIT] && keySelect) begin
                // Compare on close of entry; backdoor enable gates it [R20] [R11]
                if (state_ff.keySt == KEY_COLLECT && state_ff.keyIdx == 4'(KEY_BYTES)
                    && state_ff.option[BACKDOOR_BIT] && keyMatch && state_ff.optLoaded) begin
                    nxt_state.option[1:0] = SEC_UNSECURED; // [R13] [R17]
                end
                nxt_state.keySt  = KEY_IDLE;
                nxt_state.keyIdx = 4'h0;
                nxt_state.keyBuf = '0;
            end
        end

        // Full blank check also unsecures [R17]
        if (blankCheckPass && state_ff.optLoaded) begin
            nxt_state.option[1:0] = SEC_UNSECURED;
        end

        // Read data one cycle later; option writes are dropped [R10]
        if (regRead) begin
            if (isReg(regAddr, RATIO_IDX)) begin
                nxt_state.rdData = state_ff.ratio;
            end else if (isReg(regAddr, OPTION_IDX)) begin
                nxt_state.rdData = state_ff.option & OPTION_USED; // [R9]
            end else if (isReg(regAddr, CONFIG_IDX)) begin
                nxt_state.rdData = {state_ff.cfgHi, 5'h00}; // [R18]
            end else begin
                nxt_state.rdData = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff        <= '0;
            state_ff.ratio  <= RATIO_RESET;
            state_ff.option <= OPTION_RESET;
            state_ff.cfgHi  <= CONFIG_RESET[7:5];
            state_ff.keySt  <= KEY_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Divider runs only once the ratio is loaded
    flash_clk_div #(
        .RW (RATIO_W)
    ) u_div (
        .clk             (clk),
        .resetn          (resetn),
        .enable          (ratioLoaded),
        .prescaleByEight (state_ff.ratio[PRESCALE_BIT]),
        .clockRatioField (state_ff.ratio[RATIO_W-1:0]),
        .fclkTick        (fclkTick)
    );

    assign regRdData   = state_ff.rdData;
    assign cmdGrant    = state_ff.grant;
    assign accessError = state_ff.accErr;
    assign optionValid = state_ff.optLoaded;
    // Secured until the option byte is in, since reset code is 0:0 [R15]
    assign deviceSecured  = (state_ff.option[1:0] != SEC_UNSECURED);
    assign accessBlocked  = deviceSecured && accessUnsecured; // [R16]
    assign redirectEnable = !state_ff.option[REDIRECT_BIT]; // [R14]

    a_loaded_sticky: assert property (@(posedge clk) disable iff (!resetn) // [R1]
        ratioLoaded |=> ratioLoaded)
        else $error("Loaded flag fell without reset");
    a_first_write: assert property (@(posedge clk) disable iff (!resetn) // [R1]
        regWrite && isReg(regAddr, RATIO_IDX) |=> ratioLoaded)
        else $error("Ratio write did not set loaded flag");
    a_ratio_frozen: assert property (@(posedge clk) disable iff (!resetn) // [R2]
        ratioLoaded |=> $stable(state_ff.ratio))
        else $error("Ratio changed after first write");
    a_refuse_unloaded: assert property (@(posedge clk) disable iff (!resetn) // [R3] [R21]
        cmdAttempt && !ratioLoaded |=> accessError && !cmdGrant)
        else $error("Command not refused before ratio write");
    a_grant_loaded: assert property (@(posedge clk) disable iff (!resetn) // [R3]
        cmdAttempt && ratioLoaded |=> cmdGrant && !accessError)
        else $error("Command not granted after ratio write");
    a_option_zeros: assert property (@(posedge clk) disable iff (!resetn) // [R9]
        regRead && isReg(regAddr, OPTION_IDX) |=> regRdData[5:2] == 4'h0)
        else $error("Option mirror unused bits not zero");
    a_option_load: assert property (@(posedge clk) disable iff (!resetn) // [R8]
        $rose(optionValid) |-> state_ff.option == (optionNonvolatileByte & OPTION_USED))
        else $error("Option byte not copied");
    a_option_readonly: assert property (@(posedge clk) disable iff (!resetn) // [R10]
        optionValid && !blankCheckPass && !cfgWrite |=> $stable(state_ff.option))
        else $error("Option mirror changed by a write");
    a_cfg_low_zero: assert property (@(posedge clk) disable iff (!resetn) // [R18]
        regRead && isReg(regAddr, CONFIG_IDX) |=> regRdData[4:0] == 5'h00)
        else $error("Config low bits not zero");
    a_debug_no_key: assert property (@(posedge clk) disable iff (!resetn) // [R12]
        memFromDebug && !cfgWrite |=> $stable(state_ff.keyIdx))
        else $error("Debug write counted as key byte");
    a_key_disabled: assert property (@(posedge clk) disable iff (!resetn) // [R11]
        optionValid && !state_ff.option[BACKDOOR_BIT] && !blankCheckPass
        |=> $stable(state_ff.option[1:0]))
        else $error("Security changed with backdoor disabled");
    a_blank_unsecure: assert property (@(posedge clk) disable iff (!resetn) // [R17]
        optionValid && blankCheckPass |=> !deviceSecured)
        else $error("Blank check did not unsecure");
    a_block_secured: assert property (@(posedge clk) disable iff (!resetn) // [R16]
        deviceSecured && accessUnsecured |-> accessBlocked)
        else $error("Unsecured access not blocked");
endmodule
`default_nettype wire

// File: common/flash_ctl_pkg.sv
// Shared constants for the flash clock, option and security control
package flash_ctl_pkg;
    // Register indexes on the plain register port
    localparam logic [3:0] RATIO_IDX  = 4'h0;
    localparam logic [3:0] OPTION_IDX = 4'h1;
    localparam logic [3:0] CONFIG_IDX = 4'h2;
    // Clock ratio register fields
    localparam int LOADED_BIT   = 7;
    localparam int PRESCALE_BIT = 6;
    localparam int RATIO_W      = 6;
    localparam int PRESCALE_DIV = 8;
    localparam logic [7:0] RATIO_RESET = 8'h00;
    // Option mirror fields
    localparam int BACKDOOR_BIT = 7;
    localparam int REDIRECT_BIT = 6;
    localparam logic [7:0] OPTION_USED   = 8'hc3;
    localparam logic [7:0] OPTION_RESET  = 8'h00;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    // Configuration register fields
    localparam int KEYSEL_BIT = 5;
    localparam logic [7:0] CONFIG_USED  = 8'he0;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    // Backdoor key window
    localparam logic [15:0] KEY_BASE  = 16'hffb0;
    localparam int          KEY_BYTES = 8;
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_COLLECT,
        KEY_BAD
    } key_e;
endpackage

// File: core/flash_clk_div.sv
// Flash timing clock divider: prescale by eight, then divide by ratio plus one
`timescale 1ns/1ps
`default_nettype none
module flash_clk_div
    import flash_ctl_pkg::*;
#(
    parameter int RW = RATIO_W
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          enable,
    input  wire logic          prescaleByEight,
    input  wire logic [RW-1:0] clockRatioField,
    output logic               fclkTick
);
    typedef struct packed {
        logic [2:0]    pre;
        logic [RW-1:0] cnt;
        logic          tick;
    } div_s;

    div_s state_ff;
    div_s nxt_state;
    logic preTick;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.tick = 1'b0;
        preTick = 1'b0;
        if (!enable) begin
            nxt_state.pre = 3'h0;
            nxt_state.cnt = '0;
        end else begin
            nxt_state.pre = state_ff.pre + 3'h1;
            // Bus clock, or bus clock over eight [R4]
            preTick = prescaleByEight ? (state_ff.pre == 3'(PRESCALE_DIV - 1)) : 1'b1;
            if (preTick) begin
                if (state_ff.cnt == clockRatioField) begin // Divide by ratio plus one [R5]
                    nxt_state.cnt = '0;
                    nxt_state.tick = 1'b1; // One pulse per flash clock period [R6]
                end else begin
                    nxt_state.cnt = state_ff.cnt + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign fclkTick = state_ff.tick;

    a_undivided_tick: assert property (@(posedge clk) disable iff (!resetn) // [R4] [R5]
        enable && $past(enable) && !prescaleByEight && clockRatioField == '0 |-> fclkTick)
        else $error("Undivided flash clock missed a tick");
    a_prescale_gap: assert property (@(posedge clk) disable iff (!resetn) // [R4]
        enable && prescaleByEight && fclkTick |=> !fclkTick [*7])
        else $error("Prescaled flash clock ticked too early");
endmodule
`default_nettype wire

// File: verification/tb_flash_ctl_regs.sv
// Self-checking bench for the flash clock ratio, option mirror and security logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module tb_flash_ctl_regs
    import flash_ctl_pkg::*;
();
    logic        clk;
    logic        resetn;
    logic [3:0]  regAddr;
    logic [7:0]  regWrData;
    logic        regWrite;
    logic        regRead;
    logic [7:0]  regRdData;
    logic [7:0]  optionNonvolatileByte;
    logic [63:0] backdoorKeyBytes;
    logic        memWrite;
    logic [15:0] memAddr;
    logic [7:0]  memWrData;
    logic        memFromSecure;
    logic        memFromDebug;
    logic        progEraseReq;
    logic        blankCheckPass;
    logic        cmdGrant;
    logic        accessError;
    logic        fclkTick;
    logic        accessUnsecured;
    logic        accessBlocked;
    logic        deviceSecured;
    logic        redirectEnable;
    logic        optionValid;
    logic [15:0] seed;
    logic [7:0]  q;
    logic [7:0]  nv;
    logic [7:0]  d;
    logic [5:0]  r;
    logic        p;
    int          n;
    int          miscompares;
    int          totalChecks;
    // Key attempts: good, backdoor off, from debug, wrong last byte, from unsecure code
    logic [7:0]  keyNv [5] = '{8'h80, 8'h00, 8'h80, 8'h81, 8'h80};
    logic [4:0]  keySec    = 5'h0f;
    logic [4:0]  keyDbg    = 5'h04;
    logic [4:0]  keyBad    = 5'h08;
    logic [4:0]  keyLock   = 5'h1e;

    flash_ctl_regs uut (
        .clk                   (clk),
        .resetn                (resetn),
        .regAddr               (regAddr),
        .regWrData             (regWrData),
        .regWrite              (regWrite),
        .regRead               (regRead),
        .regRdData             (regRdData),
        .optionNonvolatileByte (optionNonvolatileByte),
        .backdoorKeyBytes      (backdoorKeyBytes),
        .memWrite              (memWrite),
        .memAddr               (memAddr),
        .memWrData             (memWrData),
        .memFromSecure         (memFromSecure),
        .memFromDebug          (memFromDebug),
        .progEraseReq          (progEraseReq),
        .blankCheckPass        (blankCheckPass),
        .cmdGrant              (cmdGrant),
        .accessError           (accessError),
        .fclkTick              (fclkTick),
        .accessUnsecured       (accessUnsecured),
        .accessBlocked         (accessBlocked),
        .deviceSecured         (deviceSecured),
        .redirectEnable        (redirectEnable),
        .optionValid           (optionValid)
    );

    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int expPeriod(input logic pre, input logic [5:0] ratio);
        return (pre ? PRESCALE_DIV : 1) * (int'(ratio) + 1);
    endfunction
    function automatic logic expSecured(input logic [7:0] opt);
        return opt[1:0] != SEC_UNSECURED;
    endfunction

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic doReset(input logic [7:0] nvByte, input logic [63:0] key);
        @(posedge clk);
        optionNonvolatileByte <= nvByte;
        backdoorKeyBytes <= key;
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        {regAddr, regWrData, regWrite} <= {a, v, 1'b1};
        @(posedge clk);
        regWrite <= 1'b0;
        #1;
    endtask
    // Read data are valid only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        {regAddr, regRead} <= {a, 1'b1};
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        q = regRdData;
    endtask
    task automatic memw(input logic [15:0] a, input logic [7:0] v, input logic s, input logic g);
        @(posedge clk);
        {memAddr, memWrData, memFromSecure, memFromDebug, memWrite} <= {a, v, s, g, 1'b1};
        @(posedge clk);
        memWrite <= 1'b0;
        #1;
    endtask
    task automatic cmd();
        @(posedge clk);
        progEraseReq <= 1'b1;
        @(posedge clk);
        progEraseReq <= 1'b0;
        #1;
    endtask
    // Cycles from one timing tick to the next, bounded so a dead divider cannot hang
    task automatic measure(output int cnt);
        cnt = 0;
        while (fclkTick !== 1'b1 && cnt < 2000) begin @(posedge clk); #1; cnt++; end
        cnt = 0;
        do begin @(posedge clk); #1; cnt++; end while (fclkTick !== 1'b1 && cnt < 2000);
    endtask
    task automatic closeOut();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        {resetn, regAddr, regWrData, regWrite, regRead, memWrite, memAddr, memWrData} = '0;
        {memFromSecure, memFromDebug, progEraseReq, blankCheckPass, accessUnsecured} = '0;
        {optionNonvolatileByte, backdoorKeyBytes, miscompares, totalChecks} = '0;
        seed = 16'hdee6;
        doReset(8'hff, 64'h0);
        rd(OPTION_IDX); `CHK(q, 8'hff & OPTION_USED)
        wr(OPTION_IDX, 8'h00); rd(OPTION_IDX); `CHK(q, 8'hff & OPTION_USED)
        rd(CONFIG_IDX); `CHK(q, CONFIG_RESET)
        wr(CONFIG_IDX, 8'hff); rd(CONFIG_IDX); `CHK(q, 8'hff & CONFIG_USED)
        wr(CONFIG_IDX, 8'h00);
        memw(KEY_BASE + 16'h3, 8'h55, 1'b1, 1'b0); `CHK(accessError, 1'b1)
        rd(4'hf); `CHK(q, 8'h00)
        $display("test register_map done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsrNext(seed);
            nv = {seed[7:2], 2'(i)};
            p = (i == 1) || (i == 2);
            // 8 x 63 bus cycles gives a flash clock inside the legal band
            r = (i == 2) ? 6'h3e : (i == 3) ? 6'h0 : (p ? {3'h0, seed[10:8]} : seed[13:8]);
            doReset(nv, 64'h0);
            rd(OPTION_IDX); `CHK(q, nv & OPTION_USED)
            `CHK(optionValid, 1'b1)
            `CHK(deviceSecured, expSecured(nv))
            `CHK(redirectEnable, ~nv[REDIRECT_BIT])
            @(posedge clk); accessUnsecured <= 1'b1;
            @(posedge clk); #1; `CHK(accessBlocked, expSecured(nv))
            @(posedge clk); accessUnsecured <= 1'b0;
            #1; `CHK(accessBlocked, 1'b0)
            cmd(); `CHK({accessError, cmdGrant}, 2'b10)
            d = {seed[15], p, r};
            wr(RATIO_IDX, d); rd(RATIO_IDX); `CHK(q, {1'b1, p, r})
            wr(RATIO_IDX, ~d); rd(RATIO_IDX); `CHK(q, {1'b1, p, r})
            cmd(); `CHK({accessError, cmdGrant}, 2'b01)
            memw(KEY_BASE, 8'h12, 1'b1, 1'b0); `CHK(cmdGrant, 1'b1)
            measure(n); `CHK(n, expPeriod(p, r))
            $display("test ratio_and_code %0d done", i);
        end
        for (int j = 0; j < 5; j++) begin
            seed = lfsrNext(seed);
            doReset(keyNv[j], {seed, seed ^ 16'h3c3c, ~seed, seed ^ 16'ha5a5});
            wr(CONFIG_IDX, 8'h20);
            for (int k = 0; k < KEY_BYTES; k++) begin
                memw(KEY_BASE + 16'(k), backdoorKeyBytes[8*k +: 8] ^ {7'h0, keyBad[j] && k == 7},
                     keySec[j], keyDbg[j]);
            end
            wr(CONFIG_IDX, 8'h00); `CHK(deviceSecured, keyLock[j])
            nv = keyNv[j] & OPTION_USED;
            rd(OPTION_IDX); `CHK(q, keyLock[j] ? nv : {nv[7:2], SEC_UNSECURED})
            $display("test backdoor_key %0d done", j);
        end
        // Last attempt left the part secured, so a blank pass must unlock it
        @(posedge clk); blankCheckPass <= 1'b1;
        @(posedge clk); blankCheckPass <= 1'b0;
        #1; `CHK(deviceSecured, 1'b0)
        $display("test blank_check done");
        closeOut();
    end

    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        $display("watchdog expired");
        closeOut();
    end
endmodule
`default_nettype wire
